/* core/oss_host.sv */
// controller end: apb registers driving the serial link as master
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module oss_host
   import oss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   oss_link_if.host link,
   input wire logic pwm_five,
   input wire logic pwm_six
);
   typedef struct packed {
      oss_hstate_t st;
      logic [7:0] len, cnt, div;
      logic [31:0] tx, rx;
      logic en, busy, done;
      logic [31:0] gap;
      logic cs_n, sck, mosi;
      logic [1:0] miso_s;
      logic [31:0] rdata;
      logic rdy, err, d5, d6;
   } oss_host_t;
   oss_host_t s_reg, s_next;
   logic acc;
   assign acc = psel & penable & ~s_reg.rdy;

   // =========================================
   // apb slave and frame engine; one wait state on each access
   always_comb begin
      s_next = s_reg;
      s_next.miso_s = {s_reg.miso_s[0], link.sdo_o & link.sdo_oe};
      s_next.rdy = acc;
      s_next.err = 1'b0;
      s_next.d5 = pwm_five;
      s_next.d6 = pwm_six;
      if (s_reg.gap != 32'h0) begin
         s_next.gap = s_reg.gap - 32'h1;
      end
      // read data and error are prepared in the wait state
      if (acc) begin
         s_next.rdata = 32'h0;
         unique case (paddr)
            OSS_A_CTRL: s_next.rdata = {16'h0, s_reg.len, 6'h0, s_reg.en, 1'b0};
            OSS_A_TXD: s_next.rdata = s_reg.tx;
            OSS_A_RXD: s_next.rdata = s_reg.rx;
            OSS_A_STAT: s_next.rdata = {29'h0, s_reg.gap == 32'h0, s_reg.done, s_reg.busy};
            default: s_next.err = 1'b1;
         endcase
      end
      // writes land only at the edge that sees pready high
      if (psel && penable && pwrite && s_reg.rdy) begin
         if (paddr == OSS_A_CTRL) begin
            s_next.en = pwdata[OSS_CTRL_EN];
            s_next.len = pwdata[OSS_CTRL_LEN_LSB +: 8];
            // a busy link ignores a new start
            if (pwdata[OSS_CTRL_GO] && !s_reg.busy) begin
               s_next.busy = 1'b1;
               s_next.done = 1'b0;
               s_next.st = OSS_H_LEAD;
               s_next.cnt = pwdata[OSS_CTRL_LEN_LSB +: 8];
               s_next.div = OSS_SCK_HALF;
               s_next.cs_n = 1'b0;                                          // sclk already low
            end
         end
         if (paddr == OSS_A_TXD && !s_reg.busy) begin
            s_next.tx = pwdata;
         end
      end
      // link sequencing: msb of the frame sits at tx bit len-1
      if (s_reg.st != OSS_H_IDLE) begin
         if (s_reg.div != 8'h00) begin
            s_next.div = s_reg.div - 8'h01;
         end else begin
            s_next.div = OSS_SCK_HALF;
            unique case (s_reg.st)
               OSS_H_LEAD: begin
                  s_next.mosi = s_reg.tx[s_reg.cnt[4:0] - 5'h1];
                  s_next.sck = 1'b1;
                  s_next.st = OSS_H_SHIFT;
               end
               OSS_H_SHIFT: begin
                  if (s_reg.sck) begin
                     // device samples on this fall; we take its bit here too
                     s_next.sck = 1'b0;
                     s_next.rx = {s_reg.rx[30:0], s_reg.miso_s[1]};
                     s_next.cnt = s_reg.cnt - 8'h01;
                     if (s_reg.cnt == 8'h01) begin
                        s_next.st = OSS_H_TAIL;
                     end
                  end else begin
                     s_next.mosi = s_reg.tx[s_reg.cnt[4:0] - 5'h1];
                     s_next.sck = 1'b1;
                  end
               end
               OSS_H_TAIL: begin
                  s_next.cs_n = 1'b1;                                       // sclk low at rise
                  s_next.busy = 1'b0;
                  s_next.done = 1'b1;
                  s_next.gap = 32'(OSS_GAP_CYC);
                  s_next.st = OSS_H_IDLE;
               end
               default: s_next.st = OSS_H_IDLE;
            endcase
         end
      end
   end

   // =========================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.cs_n <= 1'b1;
         s_reg.st <= OSS_H_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.rdata;
   assign pready = s_reg.rdy;
   assign pslverr = s_reg.err;
   assign link.cs_n = s_reg.cs_n;
   assign link.sclk = s_reg.sck;
   assign link.serial_command_input = s_reg.mosi;
   assign link.enable = s_reg.en;
   assign link.direct_drive_input_five = s_reg.d5;
   assign link.direct_drive_input_six = s_reg.d6;
endmodule

/* core/oss_pkg.sv */
// shared constants and types for the octal switch serial control link
package oss_pkg;
   // =========================================
   // word layout
   localparam int OSS_WORD_W = 16;
   localparam int OSS_NCH = 8;
   localparam int OSS_OUT_LSB = 0;
   localparam int OSS_DET_LSB = 8;
   localparam int OSS_MIN_PULSES = 16;
   localparam int OSS_PULSE_STEP = 8;
   localparam logic [15:0] OSS_CMD_RESET = 16'h0000;
   // =========================================
   // timing
   localparam int OSS_PCLK_MHZ = 100;
   localparam int OSS_GAP_US = 300;
   localparam int OSS_GAP_CYC = OSS_GAP_US * OSS_PCLK_MHZ + 1; // strictly more than the gap
   localparam logic [7:0] OSS_SCK_HALF = 8'h06;                // link clock half period is this plus one pclk
   // =========================================
   // host register map (apb byte addresses)
   localparam logic [7:0] OSS_A_CTRL = 8'h00;
   localparam logic [7:0] OSS_A_TXD = 8'h04;
   localparam logic [7:0] OSS_A_RXD = 8'h08;
   localparam logic [7:0] OSS_A_STAT = 8'h0c;
   localparam int OSS_CTRL_GO = 0;
   localparam int OSS_CTRL_EN = 1;
   localparam int OSS_CTRL_LEN_LSB = 8; // frame length in bits, 8 bits wide
   localparam int OSS_STAT_BUSY = 0;
   localparam int OSS_STAT_DONE = 1;
   localparam int OSS_STAT_GAPOK = 2;
   typedef enum logic [1:0] {OSS_H_IDLE = 2'b00, OSS_H_LEAD = 2'b01, OSS_H_SHIFT = 2'b11,
      OSS_H_TAIL = 2'b10} oss_hstate_t;
endpackage

/* core/oss_link_if.sv */
// serial link between controller and switch
`timescale 1ns/1ps
interface oss_link_if;
   logic cs_n;
   logic sclk;
   logic serial_command_input;
   logic sdo_o;
   logic sdo_oe;
   logic enable;
   logic direct_drive_input_five;
   logic direct_drive_input_six;
   modport host (output cs_n, output sclk, output serial_command_input, input sdo_o, input sdo_oe,
      output enable, output direct_drive_input_five, output direct_drive_input_six);
   modport dev (input cs_n, input sclk, input serial_command_input, output sdo_o, output sdo_oe,
      input enable, input direct_drive_input_five, input direct_drive_input_six);
endinterface

/* core/oss_device.sv */
// switch end: serial shift register, command latch and fault reporting
// Function
// - command bits 0..7 switch outputs one..eight
// - bits 8..15 enable open-load detect currents
// - status upper byte always reads zero
// - status bits 0..7 flag each output fault
// - open load while on not reported
// - open load off reported only with current
// - overvoltage forces all off, then resumes
// - overtemperature stops only that output
// - sleep or supply loss resets registers
// - host commands off before sleep entry
// - status shifts out while command shifts in
// - host pairs status with previous command
// - host waits over 300 us between writes; oss_host only flags it in status bit 2 and does not hold back a start
// - 32-bit frame echoes first sixteen bits
// - last sixteen bits form the command
// - accept only 16 plus multiples of 8
// - sample falling, change rising, msb first
// - chip select high ignores clock, tristates
// - chip select rise loads command latch
// - outputs five, six ored with direct pins
`timescale 1ns/1ps
module oss_device
   import oss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   oss_link_if.dev link,
   input wire logic logic_supply_ok,
   input wire logic supply_overvoltage,
   input wire logic [7:0] thermal_limit,
   input wire logic [7:0] short_fault,
   input wire logic [7:0] open_load,
   output logic [7:0] driver_on,
   output logic [7:0] detect_current_on,
   output logic [15:0] command_word
);
   typedef struct packed {
      logic [1:0] cs_s, sck_s, di_s, en_s, d5_s, d6_s;
      logic cs_d, sck_d;
      logic [15:0] shift;
      logic [7:0] pulses;
      logic [15:0] cmd;
      logic do_bit, do_oe;
      logic [7:0] drv, det;
   } oss_dev_t;
   oss_dev_t s_reg, s_next;

   // =========================================
   // fault word from the analog sense inputs
   logic [7:0] fault_now;
   always_comb begin
      for (int i = 0; i < OSS_NCH; i++) begin
         fault_now[i] = thermal_limit[i] | short_fault[i]
            | (open_load[i] & ~s_reg.cmd[OSS_OUT_LSB + i]
               & s_reg.cmd[OSS_DET_LSB + i]);
      end
   end

   // =========================================
   // next state
   logic cs_fall, cs_rise, sck_rise, sck_fall, asleep;
   logic [7:0] want;
   always_comb begin
      s_next = s_reg;
      // two-stage synchronisers; only stage 2 is read by logic
      s_next.cs_s = {s_reg.cs_s[0], link.cs_n};
      s_next.sck_s = {s_reg.sck_s[0], link.sclk};
      s_next.di_s = {s_reg.di_s[0], link.serial_command_input};
      s_next.en_s = {s_reg.en_s[0], link.enable};
      s_next.d5_s = {s_reg.d5_s[0], link.direct_drive_input_five};
      s_next.d6_s = {s_reg.d6_s[0], link.direct_drive_input_six};
      s_next.cs_d = s_reg.cs_s[1];
      s_next.sck_d = s_reg.sck_s[1];
      cs_fall = s_reg.cs_d & ~s_reg.cs_s[1];
      cs_rise = ~s_reg.cs_d & s_reg.cs_s[1];
      sck_rise = ~s_reg.sck_d & s_reg.sck_s[1] & ~s_reg.cs_s[1];
      sck_fall = s_reg.sck_d & ~s_reg.sck_s[1] & ~s_reg.cs_s[1];
      asleep = ~s_reg.en_s[1] | ~logic_supply_ok;
      if (cs_fall) begin
         s_next.shift = {8'h00, fault_now};
         s_next.pulses = 8'h00;
         s_next.do_oe = 1'b1;
         s_next.do_bit = 1'b0;                                              // msb is always zero
      end
      if (sck_fall) begin
         // shift in on falling edge; old msb has already gone out
         s_next.shift = {s_reg.shift[14:0], s_reg.di_s[1]};
         if (s_reg.pulses != 8'hff) begin
            s_next.pulses = s_reg.pulses + 8'h01;
         end
      end
      if (sck_rise && s_reg.pulses != 8'h00) begin
         s_next.do_bit = s_reg.shift[15];
      end
      if (cs_rise) begin
         s_next.do_oe = 1'b0;
         if (s_reg.pulses >= 8'(OSS_MIN_PULSES) && s_reg.pulses[2:0] == 3'b000) begin
            s_next.cmd = s_reg.shift;
         end
      end
      if (asleep) begin
         s_next.cmd = OSS_CMD_RESET;
      end
      // drivers follow the command unless a protection holds them off
      want = s_reg.cmd[OSS_OUT_LSB +: OSS_NCH];
      want[4] = want[4] | s_reg.d5_s[1];
      want[5] = want[5] | s_reg.d6_s[1];
      s_next.drv = (supply_overvoltage | asleep) ? 8'h00
         : (want & ~thermal_limit);
      s_next.det = asleep ? 8'h00 : s_reg.cmd[OSS_DET_LSB +: OSS_NCH];
   end

   // =========================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.cs_s <= 2'b11;
         s_reg.cs_d <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // =========================================
   // outputs straight from flops
   assign link.sdo_o = s_reg.do_bit;
   assign link.sdo_oe = s_reg.do_oe;
   assign driver_on = s_reg.drv;
   assign detect_current_on = s_reg.det;
   assign command_word = s_reg.cmd;
endmodule

/* dv/oss_link_properties.sv */
// assertions watching the serial link between host and switch
`timescale 1ns/1ps
module oss_link_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_command_input,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic enable,
   input wire logic direct_drive_input_five,
   input wire logic direct_drive_input_six
);
   logic sclk_reg;
   logic [5:0] rise_reg;
   // =========================================
   // frame bookkeeping
   // sclk rises in the current frame; cleared while deselected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_reg <= 1'b0;
         rise_reg <= 6'h00;
      end else begin
         sclk_reg <= sclk;
         if (cs_n)
            rise_reg <= 6'h00;
         else if (sclk && !sclk_reg)
            rise_reg <= rise_reg + 6'h01;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // =========================================
   // link properties
   a_cs_sclk_low: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
      else $error("sclk high while chip select moved");
   a_din_held_fall: assert property ($fell(sclk) && !cs_n |-> $stable(serial_command_input))
      else $error("command bit moved at sampling edge");
   a_sdo_held_fall: assert property ($fell(sclk) && sdo_oe |-> $stable(sdo_o))
      else $error("status bit moved at falling edge");
   a_clock_idle_low: assert property (cs_n |-> !sclk)
      else $error("sclk high outside frame");
   a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*6])
      else $error("sclk high phase too short");
   a_oe_follows_select: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
      else $error("status output not driven after select");
   a_tristate_deselect: assert property (cs_n [*5] |-> !sdo_oe)
      else $error("status output driven while deselected");
   // lag of the device behind sclk keeps bit eight zero a few cycles past rise eight
   a_upper_byte_zero: assert property (!cs_n && sdo_oe && rise_reg < 6'd8 |-> !sdo_o)
      else $error("upper status byte not zero");
   c_frame16: cover property ($rose(cs_n) && rise_reg == 6'd16);
   c_frame32: cover property ($rose(cs_n) && rise_reg == 6'd32);
   c_frame15: cover property ($rose(cs_n) && rise_reg == 6'd15);
endmodule

/* dv/tb_octal_switch_spi_control.sv */
// self-checking bench: apb host and switch end joined by the link
`timescale 1ns/1ps
module tb_octal_switch_spi_control;
   import oss_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00, thermal_limit = 8'h00, short_fault = 8'h00, open_load = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pwm_five = 1'b0, pwm_six = 1'b0, logic_supply_ok = 1'b1, supply_overvoltage = 1'b0;
   logic [7:0] driver_on, detect_current_on, lens [3] = '{8'h0f, 8'h11, 8'h18};
   logic [15:0] command_word;
   int mismatches = 0, checked = 0;
   oss_link_if link ();
   oss_host u_oss_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host),
      .pwm_five(pwm_five), .pwm_six(pwm_six));
   oss_device u_oss_device (.pclk(pclk), .presetn(presetn), .link(link.dev), .logic_supply_ok(logic_supply_ok),
      .supply_overvoltage(supply_overvoltage), .thermal_limit(thermal_limit), .short_fault(short_fault),
      .open_load(open_load), .driver_on(driver_on), .detect_current_on(detect_current_on),
      .command_word(command_word));
   oss_link_properties u_oss_link_properties (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n), .sclk(link.sclk),
      .serial_command_input(link.serial_command_input), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
      .enable(link.enable), .direct_drive_input_five(link.direct_drive_input_five),
      .direct_drive_input_six(link.direct_drive_input_six));
   // =========================================
   // clock and helpers
   always #5 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // expected status: open load only counts while off with detect current
   function automatic logic [7:0] flt(input logic [15:0] c);
      return short_fault | thermal_limit | (open_load & ~c[7:0] & c[15:8]);
   endfunction
   // full frame with enable kept high, leaves received bits in rd
   task automatic frame(input logic [7:0] len, input logic [31:0] tx);
      apb(1'b1, OSS_A_TXD, tx);
      apb(1'b1, OSS_A_CTRL, {16'h0000, len, 8'h03});
      do apb(1'b0, OSS_A_STAT, 32'h0); while (rd[OSS_STAT_BUSY] === 1'b1);
      apb(1'b0, OSS_A_RXD, 32'h0);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // =========================================
   // tests
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(command_word, 16'h0000);
      chk(detect_current_on, 8'h00);
      apb(1'b1, OSS_A_CTRL, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test reset and map done");
      short_fault <= 8'h80;
      open_load <= 8'h4f;
      frame(8'h10, 32'h0f33);
      chk(rd, {24'h0, flt(16'h0)});
      chk({command_word, driver_on, detect_current_on}, 32'h0f33330f);
      apb(1'b0, OSS_A_STAT, 32'h0);
      chk(rd[OSS_STAT_GAPOK], 1'b0);
      do apb(1'b0, OSS_A_STAT, 32'h0); while (rd[OSS_STAT_GAPOK] !== 1'b1);
      frame(8'h20, 32'hbeef0030);
      chk(rd, {8'h00, flt(16'h0f33), 16'hbeef});
      chk(command_word, 16'h0030);
      $display("test frames done");
      foreach (lens[i]) begin
         frame(lens[i], 32'h00ab0f05);
         chk(command_word, lens[i] == 8'h18 ? 16'h0f05 : 16'h0030);
      end
      chk(rd[23:0], {8'h00, flt(16'h0030), 8'hab});
      $display("test pulse count done");
      supply_overvoltage <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(driver_on, 8'h00);
      supply_overvoltage <= 1'b0;
      thermal_limit <= 8'h04;
      repeat (6) @(posedge pclk);
      chk(driver_on, 8'h01);
      thermal_limit <= 8'h00;
      pwm_five <= 1'b1;
      pwm_six <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(driver_on, 8'h35);
      pwm_five <= 1'b0;
      pwm_six <= 1'b0;
      $display("test shutdown and direct drive done");
      // outputs off first, detect left on so the reset is visible
      frame(8'h10, 32'hff00);
      apb(1'b1, OSS_A_CTRL, 32'h0);
      repeat (8) @(posedge pclk);
      chk({command_word, detect_current_on}, 24'h0);
      apb(1'b1, OSS_A_CTRL, 32'h2);
      repeat (8) @(posedge pclk);
      frame(8'h10, 32'hff00);
      chk(detect_current_on, 8'hff);
      logic_supply_ok <= 1'b0;
      repeat (8) @(posedge pclk);
      chk({command_word, detect_current_on}, 24'h0);
      $display("test sleep done");
      end_sim();
   end
   // watchdog well beyond the gap wait and all frames
   initial begin
      repeat (80000) @(posedge pclk);
      mismatches++;
      end_sim();
   end
endmodule
